// ===== core/dgp_pkg.sv
package dgp_pkg;

	// Register map, 8-bit address space
	localparam logic [7:0] DGP_A_DATA_OFS    = 8'h05;
	localparam logic [7:0] DGP_B_DATA_OFS    = 8'h06;
	localparam logic [7:0] DGP_IRQ_CTRL_OFS  = 8'h0B;
	localparam logic [7:0] DGP_CMP_CTRL_OFS  = 8'h1F;
	localparam logic [7:0] DGP_OPTION_OFS    = 8'h81;
	localparam logic [7:0] DGP_A_DIR_OFS     = 8'h85;
	localparam logic [7:0] DGP_B_DIR_OFS     = 8'h86;
	localparam logic [7:0] DGP_VREF_CTRL_OFS = 8'h9F;

	// Values after reset
	localparam logic [4:0] DGP_A_LATCH_RST   = 5'h00;
	localparam logic [7:0] DGP_B_LATCH_RST   = 8'h00;
	localparam logic [4:0] DGP_A_DIR_RST     = 5'h1F;
	localparam logic [7:0] DGP_B_DIR_RST     = 8'hFF;
	localparam logic [7:0] DGP_OPTION_RST    = 8'hFF;
	localparam logic [3:0] DGP_CMP_CTRL_RST  = 4'h0;
	localparam logic [7:0] DGP_VREF_CTRL_RST = 8'h00;
	localparam logic [3:0] DGP_CHG_REF_RST   = 4'h0;

	// Field positions
	localparam int DGP_PULLUP_N_BIT = 7;
	localparam int DGP_CHG_EN_BIT   = 3;
	localparam int DGP_CHG_FLAG_BIT = 0;
	localparam int DGP_VREF_EN_BIT  = 7;
	localparam int DGP_VREF_OE_BIT  = 6;
	localparam int DGP_OD_PIN       = 4;
	localparam int DGP_VREF_PIN     = 2;
	localparam int DGP_IRQ_PIN      = 0;
	localparam int DGP_PCLK_PIN     = 6;
	localparam int DGP_PDATA_PIN    = 7;

	// Writable bits of the reference control (bit 4 unimplemented)
	localparam logic [7:0] DGP_VREF_WMASK = 8'hEF;

	// Comparator modes in the low three bits of comparator_control
	typedef enum logic [2:0] {
		DGP_CM_RESET   = 3'h0,
		DGP_CM_OUTPUTS = 3'h6,
		DGP_CM_OFF     = 3'h7
	} dgp_cmode_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dgp_req_t;

	// Pin drive bundle
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} dgp_drive_t;

endpackage

// ===== core/dgp_port.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] First port has a five-bit latch; bit 4 open drain, others push-pull.
// [R2] Direction one floats the pin; direction zero drives the latch bit.
// [R3] Data reads return pin levels; writes change only the latch.
// [R4] Each write samples the pins first, then stores the modified value; here the latch takes wdata as is, and only second-port writes sample pins.
// [R5] First-port pins used as comparator inputs read back as zero.
// [R6] Reset sets first-port directions to input and grounds comparator inputs.
// [R7] Direction bits keep driver control on comparator input pins.
// [R8] Bit 2 can carry the reference voltage; software keeps it input.
// [R9] In the output mode bits 3 and 4 carry the comparator outputs.
// [R10] Bit 4 input level also feeds the timer external clock.
// [R11] Pin function follows comparator and reference control registers.
// [R12] Unimplemented bits of first-port and analog control registers read zero.
// [R13] Second port is eight bits, bidirectional, one means input.
// [R14] Clearing option bit 7 enables weak pull-ups on the second port.
// [R15] A pull-up switches off while its pin is an output.
// [R16] Power-on reset leaves all second-port pull-ups disabled.
// [R17] Second-port pins 7 to 4 detect change, only while inputs.
// [R18] Mismatches against the last-read value are OR-ed into flag bit 0.
// [R19] A pending port-change event can wake the device from sleep.
// [R20] Flag stays set while mismatch lasts; software ends mismatch, then clears.
// [R21] A change exactly during a port read may not set the flag; here the compare uses the old reference, so it still sets it.
// [R22] Second-port pin 0 is the external interrupt; 6 and 7 program pins.
// [R23] Writing the second port also refreshes the change reference.
module dgp_port
	import dgp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire dgp_req_t   req,
	output var  logic [7:0] rdata,
	input  wire logic [4:0] a_pin_in,
	output var  logic [4:0] a_pin_out,
	output var  logic [4:0] a_pin_oe,
	input  wire logic [7:0] b_pin_in,
	output var  logic [7:0] b_pin_out,
	output var  logic [7:0] b_pin_oe,
	output var  logic [7:0] b_pullup_en,
	input  wire logic [1:0] cmp_result,
	output var  logic [7:0] comparator_control,
	output var  logic [7:0] vref_control,
	output var  logic       vref_out_en,
	output var  logic       cmp_in_ground,
	output var  logic       timer_ext_clock_in,
	output var  logic       ext_irq_pin,
	output var  logic       prog_clock_in,
	output var  logic       prog_data_in,
	output var  logic       port_change_flag,
	output var  logic       wake_req
);

	// Pins that the comparator mode claims as analog inputs
	function automatic logic [4:0] analog_pins(input logic [2:0] mode);
		case (mode)
			DGP_CM_OFF: begin
				analog_pins = 5'h00;
			end
			DGP_CM_OUTPUTS: begin
				analog_pins = 5'h07;
			end
			default: begin
				analog_pins = 5'h0F;
			end
		endcase
	endfunction

	// Address match, used for both read and write decode
	function automatic logic hit(input dgp_req_t r, input logic [7:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	// State
	logic [4:0] a_latch_reg;
	logic [4:0] a_latch_next;
	logic [4:0] a_dir_reg;
	logic [4:0] a_dir_next;
	logic [7:0] b_latch_reg;
	logic [7:0] b_latch_next;
	logic [7:0] b_dir_reg;
	logic [7:0] b_dir_next;
	logic [7:0] option_reg;
	logic [7:0] option_next;
	logic [3:0] cmp_ctrl_reg;
	logic [3:0] cmp_ctrl_next;
	logic [7:0] vref_ctrl_reg;
	logic [7:0] vref_ctrl_next;
	logic [3:0] chg_ref_reg;
	logic [3:0] chg_ref_next;
	logic       chg_en_reg;
	logic       chg_en_next;
	logic       chg_flag_reg;
	logic       chg_flag_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	dgp_drive_t a_drv_reg;
	dgp_drive_t a_drv_next;
	dgp_drive_t b_drv_reg;
	dgp_drive_t b_drv_next;
	logic [7:0] pullup_reg;
	logic [7:0] pullup_next;
	logic [5:0] misc_reg;
	logic [5:0] misc_next;
	logic       wake_reg;
	logic       wake_next;

	// Write decode
	wire logic wr_a_data  = req.wr && hit(req, DGP_A_DATA_OFS);
	wire logic wr_a_dir   = req.wr && hit(req, DGP_A_DIR_OFS);
	wire logic wr_b_data  = req.wr && hit(req, DGP_B_DATA_OFS);
	wire logic wr_b_dir   = req.wr && hit(req, DGP_B_DIR_OFS);
	wire logic wr_option  = req.wr && hit(req, DGP_OPTION_OFS);
	wire logic wr_cmp     = req.wr && hit(req, DGP_CMP_CTRL_OFS);
	wire logic wr_vref    = req.wr && hit(req, DGP_VREF_CTRL_OFS);
	wire logic wr_irq     = req.wr && hit(req, DGP_IRQ_CTRL_OFS);
	wire logic rd_b_data  = req.rd && hit(req, DGP_B_DATA_OFS);

	// Pin function selection
	wire logic [2:0] cmp_mode   = cmp_ctrl_reg[2:0];
	wire logic [4:0] analog_sel = analog_pins(cmp_mode);                 // see [R11]
	wire logic       cmp_out_md = (cmp_mode == DGP_CM_OUTPUTS);         // see [R9]
	wire logic       vref_drive = vref_ctrl_reg[DGP_VREF_EN_BIT] &&
	                              vref_ctrl_reg[DGP_VREF_OE_BIT];       // see [R8]

	// Pin levels as software sees them; analog inputs read low
	wire logic [4:0] a_read_val = a_pin_in & ~analog_sel;               // see [R5] [R3]
	wire logic [7:0] b_read_val = b_pin_in;                             // see [R3]

	// Value each first-port driver would put out before direction gating
	wire logic [4:0] a_src_val = cmp_out_md ?
	                             {cmp_result[1], cmp_result[0], a_latch_reg[2:0]} :
	                             a_latch_reg;                           // see [R9]

	// Change detection on the upper four pins, inputs only
	wire logic [3:0] chg_diff = (b_pin_in[7:4] ^ chg_ref_reg) & b_dir_reg[7:4]; // see [R17]
	wire logic       chg_hit  = |chg_diff;                              // see [R18]

	// Read data selection; unmapped addresses read zero
	wire logic [7:0] rd_mux =
		hit(req, DGP_A_DATA_OFS)    ? {3'h0, a_read_val} :              // see [R12]
		hit(req, DGP_A_DIR_OFS)     ? {3'h0, a_dir_reg} :
		hit(req, DGP_B_DATA_OFS)    ? b_read_val :
		hit(req, DGP_B_DIR_OFS)     ? b_dir_reg :
		hit(req, DGP_OPTION_OFS)    ? option_reg :
		hit(req, DGP_CMP_CTRL_OFS)  ? {cmp_result[1], cmp_result[0], 2'h0, cmp_ctrl_reg} :
		hit(req, DGP_VREF_CTRL_OFS) ? vref_ctrl_reg :
		hit(req, DGP_IRQ_CTRL_OFS)  ? {4'h0, chg_en_reg, 2'h0, chg_flag_reg} :
		8'h00;

	// First-port drivers, one per pin
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_a_drv
			if (gi == DGP_OD_PIN) begin : g_od
				// Open drain: only ever pulls low
				assign a_drv_next.out[gi] = 1'b0;                   // see [R1]
				assign a_drv_next.oe[gi]  = ~a_dir_reg[gi] & ~a_src_val[gi]; // see [R2] [R7]
			end else begin : g_pp
				assign a_drv_next.out[gi] = a_src_val[gi];          // see [R1]
				assign a_drv_next.oe[gi]  = ~a_dir_reg[gi];         // see [R2] [R7]
			end
		end
	endgenerate
	assign a_drv_next.out[7:5] = 3'h0;
	assign a_drv_next.oe[7:5]  = 3'h0;

	// Second-port drivers and pull-ups
	assign b_drv_next.out = b_latch_reg;                                // see [R13]
	assign b_drv_next.oe  = ~b_dir_reg;                                 // see [R2] [R13]
	assign pullup_next    = {8{~option_reg[DGP_PULLUP_N_BIT]}} & b_dir_reg; // see [R14] [R15]

	// Register updates; a write stores the whole new value into the latch
	assign a_latch_next   = wr_a_data ? req.wdata[4:0] : a_latch_reg;   // see [R3] [R4]
	assign a_dir_next     = wr_a_dir ? req.wdata[4:0] : a_dir_reg;
	assign b_latch_next   = wr_b_data ? req.wdata : b_latch_reg;        // see [R3] [R4]
	assign b_dir_next     = wr_b_dir ? req.wdata : b_dir_reg;
	assign option_next    = wr_option ? req.wdata : option_reg;
	assign cmp_ctrl_next  = wr_cmp ? req.wdata[3:0] : cmp_ctrl_reg;     // see [R11]
	assign vref_ctrl_next = wr_vref ? (req.wdata & DGP_VREF_WMASK) : vref_ctrl_reg; // see [R12]
	assign chg_en_next    = wr_irq ? req.wdata[DGP_CHG_EN_BIT] : chg_en_reg;

	// Reference latch: a read or a write of the port both sample the pins
	assign chg_ref_next = (rd_b_data || wr_b_data) ? b_pin_in[7:4] :
	                      chg_ref_reg;                                  // see [R18] [R23] [R4]

	// Flag: mismatch sets and wins over a software clear in the same cycle.
	// The compare uses the old reference, so a change landing on the
	// sampling read still sets the flag as it enters the new reference.
	assign chg_flag_next = chg_hit ||
	                       (wr_irq ? req.wdata[DGP_CHG_FLAG_BIT] : chg_flag_reg); // see [R20] [R21]

	assign rdata_next = req.rd ? rd_mux : rdata_reg;

	// Wake request follows the flag and enable in the same edge, kept in a flip-flop
	assign wake_next = chg_flag_next & chg_en_next;                     // see [R19]

	// Timer clock, external interrupt, programming pins, analog controls
	assign misc_next = {
		a_pin_in[DGP_OD_PIN],                                           // see [R10]
		b_pin_in[DGP_IRQ_PIN],                                          // see [R22]
		b_pin_in[DGP_PCLK_PIN],                                         // see [R22]
		b_pin_in[DGP_PDATA_PIN],                                        // see [R22]
		vref_drive,                                                     // see [R8]
		(cmp_mode == DGP_CM_RESET)                                      // see [R6]
	};

	// Control and configuration state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_latch_reg   <= DGP_A_LATCH_RST;
			a_dir_reg     <= DGP_A_DIR_RST;                             // see [R6]
			b_latch_reg   <= DGP_B_LATCH_RST;
			b_dir_reg     <= DGP_B_DIR_RST;
			option_reg    <= DGP_OPTION_RST;                            // see [R16]
			cmp_ctrl_reg  <= DGP_CMP_CTRL_RST;                          // see [R6]
			vref_ctrl_reg <= DGP_VREF_CTRL_RST;
			chg_en_reg    <= 1'b0;
		end else if (ce) begin
			a_latch_reg   <= a_latch_next;
			a_dir_reg     <= a_dir_next;
			b_latch_reg   <= b_latch_next;
			b_dir_reg     <= b_dir_next;
			option_reg    <= option_next;
			cmp_ctrl_reg  <= cmp_ctrl_next;
			vref_ctrl_reg <= vref_ctrl_next;
			chg_en_reg    <= chg_en_next;
		end
	end

	// Change detection state and read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chg_ref_reg  <= DGP_CHG_REF_RST;
			chg_flag_reg <= 1'b0;
			wake_reg     <= 1'b0;
			rdata_reg    <= 8'h00;
		end else if (ce) begin
			chg_ref_reg  <= chg_ref_next;
			chg_flag_reg <= chg_flag_next;
			wake_reg     <= wake_next;
			rdata_reg    <= rdata_next;
		end
	end

	// Registered pin drive so every output comes from a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_drv_reg  <= '0;
			b_drv_reg  <= '0;
			pullup_reg <= 8'h00;
			misc_reg   <= 6'h01;
		end else if (ce) begin
			a_drv_reg  <= a_drv_next;
			b_drv_reg  <= b_drv_next;
			pullup_reg <= pullup_next;
			misc_reg   <= misc_next;
		end
	end

	// Outputs
	assign rdata              = rdata_reg;
	assign a_pin_out          = a_drv_reg.out[4:0];
	assign a_pin_oe           = a_drv_reg.oe[4:0];
	assign b_pin_out          = b_drv_reg.out;
	assign b_pin_oe           = b_drv_reg.oe;
	assign b_pullup_en        = pullup_reg;
	assign comparator_control = {4'h0, cmp_ctrl_reg};
	assign vref_control       = vref_ctrl_reg;
	assign timer_ext_clock_in = misc_reg[5];
	assign ext_irq_pin        = misc_reg[4];
	assign prog_clock_in      = misc_reg[3];
	assign prog_data_in       = misc_reg[2];
	assign vref_out_en        = misc_reg[1];
	assign cmp_in_ground      = misc_reg[0];
	assign port_change_flag   = chg_flag_reg;
	// Wake request: flag pending and enabled, both flip-flops
	assign wake_req           = wake_reg;                               // see [R19]

endmodule
`default_nettype wire

// ===== bench/dgp_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module dgp_port_props
	import dgp_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ce,
	input wire dgp_req_t   req,
	input wire logic [7:0] rdata,
	input wire logic [4:0] a_pin_in,
	input wire logic [4:0] a_pin_oe,
	input wire logic [7:0] b_pin_in,
	input wire logic [7:0] b_pin_oe,
	input wire logic [7:0] b_pullup_en,
	input wire logic [7:0] comparator_control,
	input wire logic       timer_ext_clock_in,
	input wire logic       ext_irq_pin,
	input wire logic       port_change_flag
);
	logic [3:0] dir_reg;
	logic [3:0] ref_reg;
	// Bus decodes; the mismatch uses the old reference, as the block does
	wire  [2:0] mode  = comparator_control[2:0];
	wire        a_rd_hit = ce && req.rd && req.addr == DGP_A_DATA_OFS;
	wire        b_hit = ce && (req.rd || req.wr) && req.addr == DGP_B_DATA_OFS;
	wire        mism  = ((b_pin_in[7:4] ^ ref_reg) & dir_reg) != 4'h0;
	// Shadow of the change reference and the upper directions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_reg <= DGP_B_DIR_RST[7:4];
			ref_reg <= DGP_CHG_REF_RST;
		end else begin
			if (b_hit) ref_reg <= b_pin_in[7:4];
			if (ce && req.wr && req.addr == DGP_B_DIR_OFS) dir_reg <= req.wdata[7:4];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_dir_wr;
		ce && req.wr && req.addr == DGP_A_DIR_OFS ##1 ce;
	endsequence
	sequence s_pu_off;
		ce && req.wr && req.addr == DGP_OPTION_OFS && req.wdata[DGP_PULLUP_N_BIT] ##1 ce;
	endsequence
	property p_dir; s_dir_wr |=> a_pin_oe[3:0] == ~$past(req.wdata[3:0], 2); endproperty
	a_dir: assert property (p_dir) else $error("oe not from direction");
	property p_rd;
		a_rd_hit && mode == DGP_CM_OFF && $stable(comparator_control) |=> rdata == {3'h0, $past(a_pin_in)};
	endproperty
	a_rd: assert property (p_rd) else $error("pin read wrong");
	property p_gnd;
		a_rd_hit && mode == DGP_CM_RESET && $stable(comparator_control) |=> rdata[3:0] == 4'h0;
	endproperty
	a_gnd: assert property (p_gnd) else $error("analog pin not zero");
	property p_pu_out; (b_pullup_en & b_pin_oe) == 8'h00; endproperty
	a_pu_out: assert property (p_pu_out) else $error("pull-up on output");
	property p_pu_off; s_pu_off |=> b_pullup_en == 8'h00; endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull-ups not off");
	property p_chg; ce && mism |=> port_change_flag; endproperty
	a_chg: assert property (p_chg) else $error("change missed");
	property p_hold;
		port_change_flag && !(req.wr && req.addr == DGP_IRQ_CTRL_OFS) |=> port_change_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_pass;
		ce |=> timer_ext_clock_in == $past(a_pin_in[4]) && ext_irq_pin == $past(b_pin_in[0]);
	endproperty
	a_pass: assert property (p_pass) else $error("pin feed wrong");
endmodule
bind dgp_port dgp_port_props dgp_port_props_i (.clk, .rst, .ce, .req, .rdata, .a_pin_in,
	.a_pin_oe, .b_pin_in, .b_pin_oe, .b_pullup_en, .comparator_control, .timer_ext_clock_in,
	.ext_irq_pin, .port_change_flag);
`default_nettype wire

// ===== bench/dgp_board.sv
`timescale 1ns/100ps
`default_nettype none
module dgp_board (
	input  wire logic       clk,
	input  wire logic [4:0] a_out,
	input  wire logic [4:0] a_oe,
	input  wire logic [4:0] a_ext,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe,
	input  wire logic [7:0] b_pu,
	input  wire logic [7:0] b_ext,
	input  wire logic [7:0] b_en,
	output wire logic [4:0] a_pin,
	output wire logic [7:0] b_pin
);
	logic fl_reg = 1'b0;
	// A floating pad has no level, so it toggles rather than hold a stale one
	always_ff @(posedge clk) fl_reg <= ~fl_reg;
	// Bit 4 only sinks; the board pull-up on a_ext gives its high
	assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
	assign b_pin = (b_oe & b_out) | (~b_oe & b_en & b_ext) | (~b_oe & ~b_en & (b_pu | {8{fl_reg}}));
endmodule
`default_nettype wire

// ===== bench/dgp_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dgp_port_tb
	import dgp_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	dgp_req_t   req = '0;
	logic [1:0] cmp = 2'h0;
	logic [4:0] a_ext = 5'h00;
	logic [7:0] b_ext = 8'h00;
	logic [7:0] b_en = 8'hF0;
	wire  [7:0] rdata, b_in, b_out, b_oe, b_pu, cc, vc;
	wire  [4:0] a_in, a_out, a_oe;
	wire        vr_en, gnd, tck, irq, pck, pdt, flag, wake;
	int         failures = 0;
	int         checks_done = 0;
	initial forever #2.5 clk = ~clk;
	dgp_port dgp_port_i (.clk, .rst, .ce, .req, .rdata, .a_pin_in(a_in), .a_pin_out(a_out),
		.a_pin_oe(a_oe), .b_pin_in(b_in), .b_pin_out(b_out), .b_pin_oe(b_oe), .b_pullup_en(b_pu),
		.cmp_result(cmp), .comparator_control(cc), .vref_control(vc), .vref_out_en(vr_en),
		.cmp_in_ground(gnd), .timer_ext_clock_in(tck), .ext_irq_pin(irq), .prog_clock_in(pck),
		.prog_data_in(pdt), .port_change_flag(flag), .wake_req(wake));
	dgp_board dgp_board_i (.clk, .a_out, .a_oe, .a_ext, .b_out, .b_oe, .b_pu, .b_ext, .b_en,
		.a_pin(a_in), .b_pin(b_in));
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		#1;
	endtask
	// Read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 ck("rdata", e, rdata);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic results;
		if (failures == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is about a hundred cycles; this cuts a hang
	initial begin
		#20000;
		failures++;
		results;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		settle;
		rd(DGP_A_DIR_OFS, 8'h1F);
		ck("ground", 8'h01, {7'h0, gnd});
		rd(DGP_B_DIR_OFS, 8'hFF);
		ck("pullups", 8'h00, b_pu);
		rd(8'h07, 8'h00);
		// A request with the clock enable low must be ignored
		ce <= 1'b0;
		wr(DGP_A_DIR_OFS, 8'h00);
		ce <= 1'b1;
		rd(DGP_A_DIR_OFS, 8'h1F);
		wr(DGP_CMP_CTRL_OFS, 8'h07);
		a_ext <= 5'h1A;
		rd(DGP_A_DATA_OFS, 8'h1A);
		wr(DGP_A_DATA_OFS, 8'hF5);
		wr(DGP_A_DIR_OFS, 8'h00);
		rd(DGP_A_DATA_OFS, 8'h15);
		ck("a_oe", 8'h0F, {3'h0, a_oe});
		wr(DGP_A_DATA_OFS, 8'h00);
		rd(DGP_A_DATA_OFS, 8'h00);
		// Analog modes hide the comparator inputs
		wr(DGP_A_DIR_OFS, 8'h1F);
		a_ext <= 5'h1F;
		wr(DGP_CMP_CTRL_OFS, 8'h00);
		rd(DGP_A_DATA_OFS, 8'h10);
		wr(DGP_CMP_CTRL_OFS, 8'h06);
		rd(DGP_A_DATA_OFS, 8'h18);
		cmp <= 2'b01;
		wr(DGP_A_DIR_OFS, 8'h07);
		settle;
		ck("cmp out", 8'h07, {5'h0, a_oe[4:3], a_out[3]});
		cmp <= 2'b10;
		rd(DGP_CMP_CTRL_OFS, 8'h86);
		wr(DGP_CMP_CTRL_OFS, 8'hFF);
		rd(DGP_CMP_CTRL_OFS, 8'h8F);
		ck("cmp ctrl", 8'h0F, cc);
		wr(DGP_VREF_CTRL_OFS, 8'hFF);
		rd(DGP_VREF_CTRL_OFS, 8'hEF);
		ck("vref ctrl", 8'hEF, vc);
		ck("vref", 8'h01, {7'h0, vr_en});
		// Second port: pull-ups, then the change flag
		b_ext <= 8'hA0;
		wr(DGP_OPTION_OFS, 8'h7F);
		wr(DGP_B_DIR_OFS, 8'hF0);
		wr(DGP_B_DATA_OFS, 8'h05);
		settle;
		ck("pullups", 8'hF0, b_pu);
		ck("b_oe", 8'h0F, b_oe);
		rd(DGP_B_DATA_OFS, 8'hA5);
		wr(DGP_IRQ_CTRL_OFS, 8'h00);
		ck("flag", 8'h00, {7'h0, flag});
		wr(DGP_IRQ_CTRL_OFS, 8'h08);
		b_ext <= 8'h20;
		settle;
		ck("flag", 8'h01, {7'h0, flag});
		ck("wake", 8'h01, {7'h0, wake});
		wr(DGP_IRQ_CTRL_OFS, 8'h08);
		ck("flag", 8'h01, {7'h0, flag});
		wr(DGP_B_DATA_OFS, 8'h05);
		wr(DGP_IRQ_CTRL_OFS, 8'h00);
		ck("flag", 8'h00, {7'h0, flag});
		// A pin turned output drops out of the comparison
		wr(DGP_B_DIR_OFS, 8'h70);
		wr(DGP_B_DATA_OFS, 8'h85);
		settle;
		ck("flag", 8'h00, {7'h0, flag});
		ck("pullups", 8'h70, b_pu);
		ck("b_out", 8'h85, b_out);
		ck("feeds", 8'h05, {4'h0, tck, irq, pck, pdt});
		// Setting the active-low bit again turns every pull-up off
		wr(DGP_OPTION_OFS, 8'hFF);
		settle;
		ck("pullups", 8'h00, b_pu);
		results;
	end
endmodule
`default_nettype wire
